// ==== rtl/fdcst_status_core.sv ====
// Command status register, byte transfer request and command-done interrupt
// for the read and write commands of a floppy disk controller.
// Assumes a sequencer beside it reports disk events as one-cycle pulses and
// that host pins are synchronous to sys_clk.
`timescale 1ns/1ps
`include "fdcst_cfg.svh"

// Overview of operation
// - Bit 7 reads 1 while the drive is not ready or chip clear is held, else 0.
// - A read or write command written while the drive is not ready is refused.
// - Bit 6 shows write protect during writes and is cleared at command start.
// - Bit 5 holds the data mark type on reads and is forced to 0 on writes.
// - Bit 4 is set when the track, sector or side is not found; cleared at start.
// - Bit 3 flags a CRC mismatch, in an ID field when bit 4 is also set; cleared at start.
// - Bit 2 is set when a transfer request is not serviced within one byte time.
// - Bit 1 mirrors the transfer request, set when the data register needs service.
// - Bit 0 is 1 while a command runs and 0 otherwise.
// - Lost data and transfer request bits are cleared when status is updated.
// - Request and interrupt clear on the trailing read edge and leading write edge.
// - The interrupt rises at every command end and drops on status read or command write.
// - Register and direction are decoded from the selects while chip select is low.
module fdcst_status_core
#(
  parameter int SVC_MFM_CYC = `FDCST_SVC_MFM_CYC,
  parameter int SVC_FM_CYC = `FDCST_SVC_FM_CYC
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic readWriteSel,
  input wire logic registerSelectLow,
  input wire logic registerSelectHigh,
  input wire logic outputEnablePulseN,
  input wire logic writeEnablePulseN,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic driveReady,
  input wire logic chipClearInN,
  input wire logic writeProtect,
  input wire logic doubleDensity,
  input wire logic recordMissing,
  input wire logic crcMismatch,
  input wire logic markSeen,
  input wire logic markDeleted,
  input wire logic byteAssembled,
  input wire logic [7:0] assembledByte,
  input wire logic byteNeeded,
  input wire logic cmdFinished,
  output logic cmdStart,
  output logic [7:0] cmdCode,
  output logic [7:0] writeByte,
  output logic byteTransferRequest,
  output logic commandDoneIrq
);
  typedef struct packed {
    fdcst_pkg::fdcst_phase_t phase;
    fdcst_pkg::fdcst_cmd_t cmd;
    logic notReady;
    logic wprot;
    logic recType;
    logic record_missing_flag;
    logic crc;
    logic lost;
    logic byte_transfer_request;
    logic irq;
    logic [7:0] dataHoldingReg;
    logic [7:0] cmdCode;
    logic cmdStart;
    logic [7:0] dataOut;
    logic dataOe;
  } fdcst_core_t;

  fdcst_core_t st_r;
  fdcst_core_t st_nxt;
  fdcst_pkg::fdcst_cmd_t newCmd;
  logic isWrite;
  logic running;
  logic accept;
  logic drqSet;
  logic drqClr;
  logic irqSet;
  logic irqClr;
  logic lostExpired;
  logic lostSet;
  logic [1:0] regSel;
  logic [7:0] statusByte;

  fdcst_strobe_if ev ();

  // The timer below is built 16 bits wide, so longer deadlines cannot be counted.
  if (SVC_MFM_CYC < 2 || SVC_FM_CYC < 2 || SVC_MFM_CYC > 65535 || SVC_FM_CYC > 65535)
  begin : g_badSvc
    $error("Service deadlines must lie between 2 and 65535 cycles.");
  end

  fdcst_strobe_detect u_detect
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .chipSelectN(chipSelectN),
    .readWriteSel(readWriteSel),
    .registerSelectLow(registerSelectLow),
    .registerSelectHigh(registerSelectHigh),
    .outputEnablePulseN(outputEnablePulseN),
    .writeEnablePulseN(writeEnablePulseN),
    .dataIn(dataIn),
    .ev(ev)
  );

  // The deadline is measured on the request itself; the host side keeps it.
  fdcst_lost_timer #(
    .MFM_CYC(SVC_MFM_CYC),
    .FM_CYC(SVC_FM_CYC),
    .CW(16)
  ) u_timer
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .requestActive(st_r.byte_transfer_request),
    .restart(drqSet),
    .doubleDensity(doubleDensity),
    .expired(lostExpired)
  );

  function automatic fdcst_pkg::fdcst_cmd_t decodeCmd(input logic [7:0] code);
    fdcst_pkg::fdcst_cmd_t c;
    c = fdcst_pkg::CMD_OTHER;
    unique casez (code[7:4])
      4'b100?: c = fdcst_pkg::CMD_READ_SECTOR;
      4'b101?: c = fdcst_pkg::CMD_WRITE_SECTOR;
      4'hc: c = fdcst_pkg::CMD_READ_ADDR;
      4'he: c = fdcst_pkg::CMD_READ_TRACK;
      4'hf: c = fdcst_pkg::CMD_WRITE_TRACK;
      default: c = fdcst_pkg::CMD_OTHER;
    endcase
    return c;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    newCmd = decodeCmd(ev.wrData);
    isWrite = st_r.cmd == fdcst_pkg::CMD_WRITE_SECTOR
      || st_r.cmd == fdcst_pkg::CMD_WRITE_TRACK;
    running = st_r.phase == fdcst_pkg::PH_RUN;
    regSel = {registerSelectHigh, registerSelectLow};
    // On reads, a new byte while the last is unserviced also counts as lost data.
    lostSet = running && (lostExpired || (st_r.byte_transfer_request && byteAssembled && !isWrite));
    // Only read and write commands are served here, and only with the drive ready.
    accept = ev.cmdWriteTrail && !running && newCmd != fdcst_pkg::CMD_OTHER
      && driveReady && chipClearInN;

    st_nxt.notReady = !driveReady || !chipClearInN;
    st_nxt.cmdStart = accept;

    if (accept)
    begin
      st_nxt.phase = fdcst_pkg::PH_RUN;
      st_nxt.cmd = newCmd;
      st_nxt.cmdCode = ev.wrData;
      // Status update at command start wipes stale indications.
      // Clearing here rather than at command end keeps the last errors readable.
      st_nxt.wprot = 1'b0;
      st_nxt.recType = 1'b0;
      st_nxt.record_missing_flag = 1'b0;
      st_nxt.crc = 1'b0;
      st_nxt.lost = 1'b0;
    end
    else if (running)
    begin
      if (isWrite)
      begin
        st_nxt.wprot = writeProtect;
        st_nxt.recType = 1'b0;
      end
      else if (markSeen)
      begin
        st_nxt.recType = markDeleted;
      end
      if (recordMissing)
      begin
        st_nxt.record_missing_flag = 1'b1;
      end
      if (crcMismatch)
      begin
        st_nxt.crc = 1'b1;
      end
      if (lostSet)
      begin
        st_nxt.lost = 1'b1;
      end
      if (cmdFinished)
      begin
        st_nxt.phase = fdcst_pkg::PH_IDLE;
      end
    end

    drqSet = running && !cmdFinished
      && (isWrite ? byteNeeded : byteAssembled);
    drqClr = accept || ev.dataRead || ev.dataWriteLead;
    // Setting wins over a clear arriving in the same cycle.
    if (drqSet)
    begin
      st_nxt.byte_transfer_request = 1'b1;
    end
    else if (drqClr || (running && cmdFinished))
    begin
      st_nxt.byte_transfer_request = 1'b0;
    end

    if (running && !isWrite && byteAssembled)
    begin
      st_nxt.dataHoldingReg = assembledByte;
    end
    else if (ev.dataWriteTrail)
    begin
      st_nxt.dataHoldingReg = ev.wrData;
    end

    irqSet = running && cmdFinished;
    irqClr = ev.statusRead || ev.cmdWriteLead;
    if (irqSet)
    begin
      st_nxt.irq = 1'b1;
    end
    else if (irqClr)
    begin
      st_nxt.irq = 1'b0;
    end

    statusByte = `FDCST_BYTE_RST;
    // One registered copy of the pins, so a changing ready line shows one value per clock.
    statusByte[`FDCST_BIT_NOT_READY] = st_r.notReady;
    statusByte[`FDCST_BIT_WPROT] = st_r.wprot;
    statusByte[`FDCST_BIT_RECTYPE] = st_r.recType;
    statusByte[`FDCST_BIT_RNF] = st_r.record_missing_flag;
    statusByte[`FDCST_BIT_CRC] = st_r.crc;
    statusByte[`FDCST_BIT_LOST] = st_r.lost;
    statusByte[`FDCST_BIT_DRQ] = st_r.byte_transfer_request;
    statusByte[`FDCST_BIT_BUSY] = running;

    // The bus is driven only while selected for a read; other registers read zero.
    st_nxt.dataOe = !chipSelectN && readWriteSel && !outputEnablePulseN;
    // Registering the read data keeps decode glitches of the selects off the bus.
    unique case (regSel)
      `FDCST_SEL_STATUS: st_nxt.dataOut = statusByte;
      `FDCST_SEL_DATA: st_nxt.dataOut = st_r.dataHoldingReg;
      default: st_nxt.dataOut = `FDCST_BYTE_RST;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '{phase: fdcst_pkg::PH_IDLE, cmd: fdcst_pkg::CMD_OTHER, notReady: 1'b1,
        default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dataOut = st_r.dataOut;
  assign dataOe = st_r.dataOe;
  assign cmdStart = st_r.cmdStart;
  assign cmdCode = st_r.cmdCode;
  assign writeByte = st_r.dataHoldingReg;
  assign byteTransferRequest = st_r.byte_transfer_request;
  assign commandDoneIrq = st_r.irq;
endmodule

// ==== rtl/fdcst_cfg.svh ====
// Register select codes, status bit positions, reset values and timing counts.
// Assumes a 250 MHz system clock and an 8-bit host bus with two select lines.
`ifndef FDCST_CFG_SVH
`define FDCST_CFG_SVH

`define FDCST_SEL_STATUS 2'h0
`define FDCST_SEL_DATA 2'h3

`define FDCST_BIT_NOT_READY 7
`define FDCST_BIT_WPROT 6
`define FDCST_BIT_RECTYPE 5
`define FDCST_BIT_RNF 4
`define FDCST_BIT_CRC 3
`define FDCST_BIT_LOST 2
`define FDCST_BIT_DRQ 1
`define FDCST_BIT_BUSY 0

`define FDCST_BYTE_RST 8'h00

`define FDCST_CLK_MHZ 250
// Service deadlines in tenths of a microsecond: 23.5 us and 47.5 us.
`define FDCST_SVC_MFM_US10 235
`define FDCST_SVC_FM_US10 475
`define FDCST_SVC_MFM_CYC ((`FDCST_SVC_MFM_US10 * `FDCST_CLK_MHZ) / 10)
`define FDCST_SVC_FM_CYC ((`FDCST_SVC_FM_US10 * `FDCST_CLK_MHZ) / 10)

`endif

// ==== rtl/fdcst_pkg.sv ====
// Types shared by the command status block.
// Assumes the constants header is included by the files that need numbers.
package fdcst_pkg;

  typedef enum logic [0:0] {PH_IDLE, PH_RUN} fdcst_phase_t;

  typedef enum logic [2:0]
  {
    CMD_OTHER,
    CMD_READ_SECTOR,
    CMD_WRITE_SECTOR,
    CMD_READ_ADDR,
    CMD_READ_TRACK,
    CMD_WRITE_TRACK
  } fdcst_cmd_t;

endpackage

// ==== rtl/fdcst_strobe_if.sv ====
// Carries decoded host strobe events from the strobe detector to the core.
// Assumes every signal is a one-cycle pulse or a value valid with it.
`timescale 1ns/1ps
interface fdcst_strobe_if;
  logic statusRead;
  logic dataRead;
  logic cmdWriteLead;
  logic dataWriteLead;
  logic cmdWriteTrail;
  logic dataWriteTrail;
  logic [7:0] wrData;

  modport detect
  (
    output statusRead, dataRead, cmdWriteLead, dataWriteLead,
    output cmdWriteTrail, dataWriteTrail, wrData
  );
  modport core
  (
    input statusRead, dataRead, cmdWriteLead, dataWriteLead,
    input cmdWriteTrail, dataWriteTrail, wrData
  );
endinterface

// ==== rtl/fdcst_strobe_detect.sv ====
// Turns the host select, direction and strobe pins into decoded event pulses.
// Assumes the host pins are synchronous to sys_clk and strobes last two clocks or more.
`timescale 1ns/1ps
`include "fdcst_cfg.svh"
module fdcst_strobe_detect
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic readWriteSel,
  input wire logic registerSelectLow,
  input wire logic registerSelectHigh,
  input wire logic outputEnablePulseN,
  input wire logic writeEnablePulseN,
  input wire logic [7:0] dataIn,
  fdcst_strobe_if.detect ev
);
  typedef struct packed {
    logic reN;
    logic weN;
    logic selOk;
    logic rdDir;
    logic [1:0] sel;
    logic statusRead;
    logic dataRead;
    logic cmdWriteLead;
    logic dataWriteLead;
    logic cmdWriteTrail;
    logic dataWriteTrail;
    logic [7:0] wrData;
  } fdcst_det_t;

  fdcst_det_t st_r;
  fdcst_det_t st_nxt;
  logic readTrail;
  logic writeLead;
  logic writeTrail;

  always_comb
  begin
    st_nxt = st_r;
    // On trailing edges selection is taken from the cycle before the edge, so it still holds at the edge.
    readTrail = !st_r.reN && outputEnablePulseN && st_r.selOk && st_r.rdDir;
    writeLead = st_r.weN && !writeEnablePulseN && !chipSelectN && !readWriteSel;
    writeTrail = !st_r.weN && writeEnablePulseN && st_r.selOk && !st_r.rdDir;
    st_nxt.reN = outputEnablePulseN;
    st_nxt.weN = writeEnablePulseN;
    st_nxt.selOk = !chipSelectN;
    st_nxt.rdDir = readWriteSel;
    st_nxt.sel = {registerSelectHigh, registerSelectLow};
    if (!writeEnablePulseN)
    begin
      st_nxt.wrData = dataIn;
    end
    st_nxt.statusRead = readTrail && st_r.sel == `FDCST_SEL_STATUS;
    st_nxt.dataRead = readTrail && st_r.sel == `FDCST_SEL_DATA;
    st_nxt.cmdWriteLead = writeLead
      && {registerSelectHigh, registerSelectLow} == `FDCST_SEL_STATUS;
    st_nxt.dataWriteLead = writeLead
      && {registerSelectHigh, registerSelectLow} == `FDCST_SEL_DATA;
    st_nxt.cmdWriteTrail = writeTrail && st_r.sel == `FDCST_SEL_STATUS;
    st_nxt.dataWriteTrail = writeTrail && st_r.sel == `FDCST_SEL_DATA;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '{reN: 1'b1, weN: 1'b1, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ev.statusRead = st_r.statusRead;
  assign ev.dataRead = st_r.dataRead;
  assign ev.cmdWriteLead = st_r.cmdWriteLead;
  assign ev.dataWriteLead = st_r.dataWriteLead;
  assign ev.cmdWriteTrail = st_r.cmdWriteTrail;
  assign ev.dataWriteTrail = st_r.dataWriteTrail;
  assign ev.wrData = st_r.wrData;
endmodule

// ==== rtl/fdcst_lost_timer.sv ====
// Measures how long a byte transfer request stays unserviced.
// Assumes the request input is a level and restart pulses on every new request.
`timescale 1ns/1ps
module fdcst_lost_timer
#(
  parameter int MFM_CYC = 5875,
  parameter int FM_CYC = 11875,
  parameter int CW = 14
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic requestActive,
  input wire logic restart,
  input wire logic doubleDensity,
  output logic expired
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic fired;
  } fdcst_tmr_t;

  fdcst_tmr_t st_r;
  fdcst_tmr_t st_nxt;
  logic [CW-1:0] limit;

  if (MFM_CYC < 2 || FM_CYC < 2 || FM_CYC >= (1 << CW) || MFM_CYC >= (1 << CW))
  begin : g_bad
    $error("Service counts must be at least 2 and fit the counter width.");
  end

  always_comb
  begin
    st_nxt = st_r;
    limit = doubleDensity ? CW'(MFM_CYC - 1) : CW'(FM_CYC - 1);
    if (!requestActive || restart)
    begin
      st_nxt.cnt = '0;
      st_nxt.fired = 1'b0;
    end
    else if (!st_r.fired)
    begin
      if (st_r.cnt == limit)
      begin
        st_nxt.fired = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Restart is left out on purpose: it would close a loop through the request logic,
  // and a new request in the expiry cycle means the old byte was missed anyway.
  assign expired = !st_r.fired && requestActive && st_r.cnt == limit;
endmodule

// ==== testbench/fdcst_status_core_monitor.sv ====
// Concurrent checks on the host bus and sequencer ports of the status block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "fdcst_cfg.svh"
module fdcst_status_core_monitor
#(
  parameter int SVC_MFM_CYC = 20,
  parameter int SVC_FM_CYC = 40
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic readWriteSel,
  input wire logic registerSelectLow,
  input wire logic registerSelectHigh,
  input wire logic outputEnablePulseN,
  input wire logic writeEnablePulseN,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic driveReady,
  input wire logic chipClearInN,
  input wire logic byteAssembled,
  input wire logic byteNeeded,
  input wire logic cmdFinished,
  input wire logic cmdStart,
  input wire logic byteTransferRequest,
  input wire logic commandDoneIrq
);
  logic run_r;
  logic runNow;
  logic [1:0] sel;
  // Busy is rebuilt from the start and finish pulses, since it is not a port.
  assign runNow = cmdStart | run_r;
  assign sel = {registerSelectHigh, registerSelectLow};
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      run_r <= 1'b0;
    else
      run_r <= runNow & ~cmdFinished;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rdDone(s);
    $rose(outputEnablePulseN) && !$past(chipSelectN) && $past(readWriteSel) && $past(sel) == s;
  endsequence
  sequence s_wrLead(s);
    $fell(writeEnablePulseN) && !chipSelectN && !readWriteSel && sel == s;
  endsequence
  sequence s_statusRd;
    !chipSelectN && readWriteSel && !outputEnablePulseN && sel == `FDCST_SEL_STATUS;
  endsequence
  property p_startOk;
    cmdStart |-> ($past(driveReady) && $past(chipClearInN) && !run_r) ##1 !cmdStart;
  endproperty
  a_startOk: assert property (p_startOk) else $error("command accepted wrongly");
  property p_bit7;
    s_statusRd ##0 ($stable(driveReady) && $stable(chipClearInN))
      |=> dataOut[7] == !($past(driveReady) && $past(chipClearInN));
  endproperty
  a_bit7: assert property (p_bit7) else $error("not ready bit wrong");
  property p_liveBits;
    s_statusRd |=> dataOut[1:0] == {$past(byteTransferRequest), $past(runNow)};
  endproperty
  a_liveBits: assert property (p_liveBits) else $error("request or busy bit wrong");
  property p_oe; !chipSelectN && readWriteSel && !outputEnablePulseN |=> dataOe; endproperty
  a_oe: assert property (p_oe) else $error("read strobe did not enable the bus");
  property p_drqSet;
    run_r && !cmdFinished && (byteAssembled || byteNeeded) |=> byteTransferRequest;
  endproperty
  a_drqSet: assert property (p_drqSet) else $error("transfer request not raised");
  property p_done; run_r && cmdFinished |=> commandDoneIrq && !byteTransferRequest; endproperty
  a_done: assert property (p_done) else $error("command end not signalled");
  property p_drqClrRd; s_rdDone(`FDCST_SEL_DATA) |-> ##2 !byteTransferRequest; endproperty
  a_drqClrRd: assert property (p_drqClrRd) else $error("request kept after data read");
  property p_irqClrRd; s_rdDone(`FDCST_SEL_STATUS) |-> ##2 !commandDoneIrq; endproperty
  a_irqClrRd: assert property (p_irqClrRd) else $error("irq kept after status read");
  property p_drqClrWr; s_wrLead(`FDCST_SEL_DATA) |-> ##2 !byteTransferRequest; endproperty
  a_drqClrWr: assert property (p_drqClrWr) else $error("request kept after data write");
  property p_irqClrWr; s_wrLead(`FDCST_SEL_STATUS) |-> ##2 !commandDoneIrq; endproperty
  a_irqClrWr: assert property (p_irqClrWr) else $error("irq kept after command write");
endmodule

// ==== testbench/fdcst_host_model.sv ====
// Host processor model that moves one byte per call over the select and strobe pins.
// Assumes pins may change only just after a rising edge of sys_clk.
`timescale 1ns/1ps
module fdcst_host_model
(
  input wire logic sys_clk,
  input wire logic [7:0] dataOut,
  output logic chipSelectN,
  output logic readWriteSel,
  output logic registerSelectLow,
  output logic registerSelectHigh,
  output logic outputEnablePulseN,
  output logic writeEnablePulseN,
  output logic [7:0] dataIn
);
  initial
  begin
    chipSelectN = 1'b1;
    readWriteSel = 1'b1;
    {registerSelectHigh, registerSelectLow} = 2'h0;
    outputEnablePulseN = 1'b1;
    writeEnablePulseN = 1'b1;
    dataIn = 8'h00;
  end
  // A transfer takes seven clocks, far inside the byte service deadline.
  task automatic xfer(input logic rw, input logic [1:0] s, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge sys_clk);
    chipSelectN <= 1'b0;
    readWriteSel <= rw;
    {registerSelectHigh, registerSelectLow} <= s;
    dataIn <= rw ? ~dataIn : d;
    outputEnablePulseN <= ~rw;
    writeEnablePulseN <= rw;
    repeat (3) @(posedge sys_clk);
    q = dataOut;
    outputEnablePulseN <= 1'b1;
    writeEnablePulseN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chipSelectN <= 1'b1;
    // Released data lines must not keep looking valid.
    dataIn <= ~dataIn;
  endtask
endmodule

// ==== testbench/tb_fdc_rw_command_status.sv ====
// Self-checking bench for the command status block driven by a host model.
// Assumes the sequencer side is stimulated here with one-cycle pulses.
`timescale 1ns/1ps
`include "fdcst_cfg.svh"
module tb_fdc_rw_command_status;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipSelectN, readWriteSel, registerSelectLow, registerSelectHigh;
  logic outputEnablePulseN, writeEnablePulseN, dataOe, cmdStart;
  logic byteTransferRequest, commandDoneIrq;
  logic [7:0] dataIn, dataOut, cmdCode, writeByte, q;
  logic [7:0] assembledByte = 8'h00;
  logic driveReady = 1'b1;
  logic chipClearInN = 1'b1;
  logic writeProtect = 1'b0;
  logic doubleDensity = 1'b1;
  logic markDeleted = 1'b0;
  logic [5:0] ev = 6'h00;
  int n_fail = 0;
  int comparisons = 0;
  int nStarts = 0;
  fdcst_status_core #(.SVC_MFM_CYC(20), .SVC_FM_CYC(40)) i_dut (.sys_clk, .sys_rst,
    .chipSelectN, .readWriteSel, .registerSelectLow, .registerSelectHigh,
    .outputEnablePulseN, .writeEnablePulseN, .dataIn, .dataOut, .dataOe, .driveReady,
    .chipClearInN, .writeProtect, .doubleDensity, .recordMissing(ev[5]), .crcMismatch(ev[4]),
    .markSeen(ev[3]), .markDeleted, .byteAssembled(ev[2]), .assembledByte,
    .byteNeeded(ev[1]), .cmdFinished(ev[0]), .cmdStart, .cmdCode, .writeByte,
    .byteTransferRequest, .commandDoneIrq);
  fdcst_host_model i_host (.sys_clk, .dataOut, .chipSelectN, .readWriteSel,
    .registerSelectLow, .registerSelectHigh, .outputEnablePulseN, .writeEnablePulseN, .dataIn);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmdStart === 1'b1) nStarts <= nStarts + 1;
  task final_report();
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task pls(input logic [5:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 6'h00;
    @(negedge sys_clk);
  endtask
  task st(input logic [7:0] exp);
    i_host.xfer(1'b1, `FDCST_SEL_STATUS, 8'h00, q);
    chk(q, exp);
  endtask
  // Issues a command and checks whether exactly one start pulse followed.
  task cmd(input logic [7:0] c, input logic ok);
    int n0;
    n0 = nStarts;
    i_host.xfer(1'b0, `FDCST_SEL_STATUS, c, q);
    repeat (3) @(posedge sys_clk);
    chk(8'(nStarts - n0), {7'h00, ok});
    if (ok)
      chk(cmdCode, c);
  endtask
  task t_ready();
    st(8'h00);
    i_host.xfer(1'b1, 2'h1, 8'h00, q);
    chk(q, 8'h00);
    driveReady <= 1'b0;
    st(8'h80);
    cmd(8'h80, 1'b0);
    st(8'h80);
    driveReady <= 1'b1;
    chipClearInN <= 1'b0;
    st(8'h80);
    chipClearInN <= 1'b1;
    cmd(8'hd0, 1'b0);
  endtask
  task t_codes();
    automatic logic [7:0] codes [5] = '{8'h80, 8'ha0, 8'hc0, 8'he0, 8'hf0};
    foreach (codes[i])
    begin
      cmd(codes[i], 1'b1);
      st(8'h01);
      pls(6'h01);
      chk(commandDoneIrq, 1'b1);
      st(8'h00);
      chk(commandDoneIrq, 1'b0);
    end
  endtask
  task t_read();
    writeProtect <= 1'b1;
    cmd(8'h80, 1'b1);
    cmd(8'hc0, 1'b0);
    st(8'h01);
    markDeleted <= 1'b1;
    assembledByte <= 8'h5a;
    pls(6'h0c);
    chk(byteTransferRequest, 1'b1);
    st(8'h23);
    i_host.xfer(1'b1, `FDCST_SEL_DATA, 8'h00, q);
    chk(q, 8'h5a);
    chk(byteTransferRequest, 1'b0);
    pls(6'h04);
    repeat (25) @(posedge sys_clk);
    pls(6'h30);
    pls(6'h01);
    chk(byteTransferRequest, 1'b0);
    chk(commandDoneIrq, 1'b1);
    st(8'h3c);
    chk(commandDoneIrq, 1'b0);
    st(8'h3c);
  endtask
  task t_write();
    doubleDensity <= 1'b0;
    cmd(8'ha0, 1'b1);
    st(8'h41);
    pls(6'h02);
    repeat (22) @(posedge sys_clk);
    st(8'h43);
    i_host.xfer(1'b0, `FDCST_SEL_DATA, 8'ha5, q);
    chk(byteTransferRequest, 1'b0);
    chk(writeByte, 8'ha5);
    pls(6'h01);
    chk(commandDoneIrq, 1'b1);
    cmd(8'hf0, 1'b1);
    chk(commandDoneIrq, 1'b0);
    st(8'h41);
    pls(6'h01);
    st(8'h40);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_ready();
    t_codes();
    t_read();
    t_write();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule
bind fdcst_status_core fdcst_status_core_monitor
  #(.SVC_MFM_CYC(SVC_MFM_CYC), .SVC_FM_CYC(SVC_FM_CYC)) i_mon (.sys_clk, .sys_rst,
  .chipSelectN, .readWriteSel, .registerSelectLow, .registerSelectHigh,
  .outputEnablePulseN, .writeEnablePulseN, .dataOut, .dataOe, .driveReady, .chipClearInN,
  .byteAssembled, .byteNeeded, .cmdFinished, .cmdStart, .byteTransferRequest,
  .commandDoneIrq);
